// *** bench/sd_chan_ctrl_props.sv ***
// Port checker for the sigma-delta channel control block.
// Assumes it is bound to sd_chan_ctrl and reads only that module's ports.
`timescale 1ns/1ps
module sd_chan_ctrl_props (
    input wire logic        SYS_CLK,        // Clock.
    input wire logic        NRST,           // Reset, active low.
    input wire logic        PSEL,           // Select.
    input wire logic        PENABLE,        // Access phase.
    input wire logic        PWRITE,         // Write.
    input wire logic [7:0]  PADDR,          // Address.
    input wire logic [31:0] PWDATA,         // Write data.
    input wire logic        PREADY,         // Ready.
    input wire logic        PSLVERR,        // Error.
    input wire logic        REF_ON,         // Reference on.
    input wire logic        REF_BUF_ON,     // Reference buffer on.
    input wire logic        EXT_REF_SEL,    // Node undriven.
    input wire logic [2:0]  CH_POWER,       // Channel powered.
    input wire logic [7:0]  DIG_IN_DISABLE, // Digital input off.
    input wire logic [2:0]  CONV_REQ        // Request.
);
    default clocking dc @(posedge SYS_CLK);
    endclocking
    default disable iff (!NRST);
    logic done;
    assign done = PSEL && PENABLE && PREADY && PWRITE;
    property p_ready; PSEL && $rose(PENABLE) |=> PREADY ##1 !PREADY; endproperty
    a_ready: assert property (p_ready) else $error("ready not in second access cycle");
    property p_err; PSEL && $rose(PENABLE) && PADDR == 8'h08 |=> PSLVERR && PREADY; endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_ref_on;
        done && PADDR == 8'h00 |-> ##2 REF_ON == $past(PWDATA[0], 2);
    endproperty
    a_ref_on: assert property (p_ref_on) else $error("reference enable wrong");
    property p_ref_buf;
        done && PADDR == 8'h00 |-> ##2 REF_BUF_ON == $past(PWDATA[1], 2);
    endproperty
    a_ref_buf: assert property (p_ref_buf) else $error("reference buffer wrong");
    property p_ext_ref; EXT_REF_SEL == (!REF_ON && !REF_BUF_ON); endproperty
    a_ext_ref: assert property (p_ext_ref) else $error("reference node state wrong");
    property p_ref_hold; !$past(done && PADDR == 8'h00) |=> $stable(REF_ON); endproperty
    a_ref_hold: assert property (p_ref_hold) else $error("reference changed alone");
    property p_pin;
        done && PADDR == 8'h04 |-> ##2 DIG_IN_DISABLE == $past(PWDATA[7:0], 2);
    endproperty
    a_pin: assert property (p_pin) else $error("pin disable wrong");
    property p_req; (CONV_REQ & ~$past(CH_POWER)) == 3'h0; endproperty
    a_req: assert property (p_req) else $error("request from idle channel");
    c_req: cover property (CONV_REQ[2]);
    c_err: cover property (PSLVERR);
    c_down: cover property ($fell(CH_POWER[0]));
endmodule

bind sd_chan_ctrl sd_chan_ctrl_props sd_chan_ctrl_props_inst (.SYS_CLK, .NRST, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .PREADY, .PSLVERR, .REF_ON, .REF_BUF_ON, .EXT_REF_SEL, .CH_POWER,
    .DIG_IN_DISABLE, .CONV_REQ);

// *** bench/sd_mod_model.sv ***
// First-order modulator model for three channels, one bit per tick.
// Assumes a level of all ones is full scale and ticks come from the block.
`timescale 1ns/1ps
module sd_mod_model (
    input  wire logic        clk,  // System clock.
    input  wire logic        tick, // Modulator tick.
    input  wire logic [2:0]  pwr,  // Channel powered.
    input  wire logic [47:0] lvl,  // Level per channel.
    output logic      [2:0]  bits  // Bit per channel.
);
    logic [15:0] acc [3] = '{default: 16'h0};
    logic [16:0] sum;
    initial bits = 3'h0;
    // An idle channel toggles its bit, so a stale level is never mistaken for data.
    always @(posedge clk)
        for (int g = 0; g < 3; g++)
        begin
            sum = acc[g] + lvl[16*g +: 16];
            acc[g] <= pwr[g] ? (tick ? sum[15:0] : acc[g]) : 16'h0;
            bits[g] <= pwr[g] ? (tick ? sum[16] : bits[g]) : ~bits[g];
        end
endmodule

// *** bench/sigma_delta_channel_control_tb.sv ***
// Self-checking bench for sd_chan_ctrl with a modulator model on its bit inputs.
// Assumes ratio 256 and the system clock as modulator tick until the last scenario.
`timescale 1ns/1ps
module sigma_delta_channel_control_tb;
    logic        SYS_CLK = 1'b0, NRST = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic        EXT_TICK = 1'b0, PREADY, PSLVERR, MOD_STROBE, REF_ON, REF_BUF_ON, EXT_REF_SEL;
    logic [7:0]  PADDR = 8'h00, DIG_IN_DISABLE;
    logic [31:0] PWDATA = 32'h0, PRDATA, rdat, r;
    logic [2:0]  MOD_BIT, CH_POWER, CONV_REQ;
    logic [8:0]  INPUT_SEL, GAIN_SEL;
    logic [5:0]  BUF_SPEED;
    logic [47:0] lvl = 48'h8000_ffff_0000;
    logic        rerr;
    int          error_cnt = 0, n_checks = 0, seed = 75, n;
    sd_chan_ctrl sd_chan_ctrl_inst (.SYS_CLK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
        .PRDATA, .PREADY, .PSLVERR, .EXT_TICK, .MOD_BIT, .MOD_STROBE, .REF_ON, .REF_BUF_ON,
        .EXT_REF_SEL, .CH_POWER, .INPUT_SEL, .GAIN_SEL, .BUF_SPEED, .DIG_IN_DISABLE, .CONV_REQ);
    sd_mod_model sd_mod_model_inst (.clk(SYS_CLK), .tick(MOD_STROBE), .pwr(CH_POWER), .lvl(lvl),
        .bits(MOD_BIT));
    always #2.5 SYS_CLK = ~SYS_CLK;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Sinc3 of a first-order stream still carries about one part in the ratio of error.
    function automatic logic near(input logic [15:0] a, input logic [15:0] b);
        return (a > b ? a - b : b - a) <= 16'h0400;
    endfunction
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (10000) @(posedge SYS_CLK);
        error_cnt++;
        end_sim();
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        do
            @(posedge SYS_CLK);
        while (PREADY !== 1'b1);
        rdat = PRDATA;
        rerr = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        // Registered outputs follow the landed write one cycle later, so wait for them.
        repeat (2) @(posedge SYS_CLK);
    endtask
    task automatic wait_req(input int g);
        for (n = 0; n < 1200 && CONV_REQ[g] !== 1'b1; n++)
            @(posedge SYS_CLK);
    endtask
    initial
    begin
        repeat (12) @(posedge SYS_CLK);
        NRST <= 1'b1;
        @(posedge SYS_CLK);
        chk("ext ref at reset", 32'(EXT_REF_SEL), 32'h1);
        chk("power at reset", 32'(CH_POWER), 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, 8'h00, 32'((i + 2) % 4));
            chk("ref on", 32'(REF_ON), 32'(((i + 2) % 4) & 1));
            chk("ref buf", 32'(REF_BUF_ON), 32'(((i + 2) % 4) >> 1));
        end
        apb(1'b0, 8'h08, 32'h0);
        chk("unmapped", {rdat[30:0], rerr}, 32'h1);
        r = $random(seed);
        apb(1'b1, 8'h04, r);
        chk("pin disable", 32'(DIG_IN_DISABLE), 32'(r[7:0]));
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, 8'h14, 32'((i % 4) << 8 | i << 3 | i));
            chk("pair", 32'(INPUT_SEL[2:0]), 32'(i));
            chk("gain", 32'(GAIN_SEL[2:0]), 32'(i < 6 ? i : 5));
            chk("buffer", 32'(BUF_SPEED[1:0]), 32'(i % 4));
            chk("others", 32'(INPUT_SEL[8:3]), 32'h0);
        end
        lvl[15:0] <= 16'($random(seed));
        apb(1'b1, 8'h34, 32'h0c0);
        apb(1'b1, 8'h30, 32'h1);
        wait_req(2);
        chk("delay three", 32'(n > 250 && n < 275), 32'h1);
        apb(1'b1, 8'h10, 32'h1);
        apb(1'b1, 8'h20, 32'h1);
        chk("power up", 32'(CH_POWER), 32'h7);
        wait_req(1);
        chk("delay zero", 32'(n > 1010 && n < 1040), 32'h1);
        apb(1'b0, 8'h20, 32'h0);
        chk("flag set", rdat, 32'h3);
        apb(1'b0, 8'h28, 32'h0);
        chk("full scale", rdat, 32'hffff);
        apb(1'b0, 8'h20, 32'h0);
        chk("flag read clear", rdat, 32'h1);
        apb(1'b0, 8'h38, 32'h0);
        chk("half scale", rdat, 32'h8000);
        apb(1'b0, 8'h18, 32'h0);
        chk("average", 32'(near(rdat[15:0], lvl[15:0])), 32'h1);
        apb(1'b1, 8'h14, 32'h13);
        chk("pair held", 32'(INPUT_SEL[2:0]), 32'h7);
        repeat (260) @(posedge SYS_CLK);
        chk("pair applied", {INPUT_SEL[2:0], GAIN_SEL[2:0]}, 32'h1a);
        wait_req(0);
        chk("settle delay", 32'(n > 750 && n < 1100), 32'h1);
        EXT_TICK <= 1'b1;
        apb(1'b1, 8'h00, 32'h0d5);
        n = 0;
        repeat (64)
        begin
            @(posedge SYS_CLK);
            n += MOD_STROBE;
        end
        chk("tick divide", 32'(n), 32'h20);
        apb(1'b1, 8'h10, 32'h0);
        chk("power down", 32'(CH_POWER[0]), 32'h0);
        chk("ref kept", 32'(REF_ON), 32'h1);
        end_sim();
    end
endmodule

// *** rtl/sd_chan_ctrl.sv ***
// Digital control of a multichannel sigma-delta converter: sinc3 decimation, input and gain
// shadowing, first-request delay, reference and power control, APB register slave.
// Assumes each MOD_BIT line is the modulator bit, valid on the cycle MOD_STROBE is high.
`timescale 1ns/1ps
`include "sd_chan_defs.svh"

module sd_chan_ctrl (
    input  wire logic                     SYS_CLK,        // System clock, 200 MHz.
    input  wire logic                     NRST,           // Asynchronous reset, active low.
    input  wire logic                     PSEL,           // APB select.
    input  wire logic                     PENABLE,        // APB access phase.
    input  wire logic                     PWRITE,         // APB direction, high for write.
    input  wire logic [`ADDR_W-1:0]       PADDR,          // APB byte address.
    input  wire logic [31:0]              PWDATA,         // APB write data.
    output logic      [31:0]              PRDATA,         // APB read data.
    output logic                          PREADY,         // APB ready.
    output logic                          PSLVERR,        // APB error on unmapped address.
    input  wire logic                     EXT_TICK,       // Alternate modulator clock source.
    input  wire logic [`NUM_CH-1:0]       MOD_BIT,        // Modulator bit stream per channel.
    output logic                          MOD_STROBE,     // Modulator clock tick.
    output logic                          REF_ON,         // Internal reference powered.
    output logic                          REF_BUF_ON,     // Reference output buffer on.
    output logic                          EXT_REF_SEL,    // Reference node left undriven.
    output logic      [`NUM_CH-1:0]       CH_POWER,       // Channel modulator powered.
    output logic      [3*`NUM_CH-1:0]     INPUT_SEL,      // Active input pair per channel.
    output logic      [3*`NUM_CH-1:0]     GAIN_SEL,       // Active amplifier gain per channel.
    output logic      [2*`NUM_CH-1:0]     BUF_SPEED,      // Input buffer speed per channel.
    output logic      [7:0]               DIG_IN_DISABLE, // Digital input off per analog pin.
    output logic      [`NUM_CH-1:0]       CONV_REQ        // Conversion request per channel.
);

    // ****************************************
    // Bus slave
    // ****************************************
    logic [8:0]             global_reg;
    logic [7:0]             pin_en_reg;
    logic                   pready_reg;
    logic [31:0]            prdata_reg;
    logic                   pslverr_reg;
    logic                   access;
    logic                   wr_done;
    logic                   rd_done;
    logic [3:0]             blk;
    logic [1:0]             sub;
    logic                   ch_hit;
    logic [1:0]             ch_idx;
    logic                   mapped;
    logic [31:0]            rd_next;
    logic [32*`NUM_CH-1:0]  ch_rd_bus;

    // The answer comes one cycle into the access phase so read data is a registered value.
    assign access  = PSEL & PENABLE;
    assign wr_done = access & pready_reg & PWRITE;
    assign rd_done = access & pready_reg & ~PWRITE;
    assign blk     = PADDR[7:4];
    assign sub     = PADDR[3:2];
    assign ch_hit  = (blk >= `CH_BASE_OFS) && (blk < `CH_BASE_OFS + 4'(`NUM_CH))
                     && (sub <= `CH_RESULT_IDX) && (PADDR[1:0] == 2'h0);
    assign ch_idx  = 2'(blk - `CH_BASE_OFS);
    assign mapped  = ch_hit || (PADDR == `GLOBAL_CTRL_OFS) || (PADDR == `PIN_ENABLE_OFS);

    always_comb
    begin
        rd_next = 32'h0000_0000;
        if (PADDR == `GLOBAL_CTRL_OFS)
            rd_next = {23'h000000, global_reg};
        else if (PADDR == `PIN_ENABLE_OFS)
            rd_next = {24'h000000, pin_en_reg};
        else if (ch_hit)
            rd_next = ch_rd_bus[32*ch_idx +: 32];
    end

    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg  <= access & ~pready_reg;
            pslverr_reg <= access & ~pready_reg & ~mapped;
            if (access && !pready_reg && !PWRITE)
                prdata_reg <= rd_next;
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            global_reg <= `GLOBAL_RST;
            pin_en_reg <= 8'h00;
        end
        else if (wr_done)
        begin
            if (PADDR == `GLOBAL_CTRL_OFS)
                global_reg <= PWDATA[8:0];
            if (PADDR == `PIN_ENABLE_OFS)
                pin_en_reg <= PWDATA[7:0];
        end
    end

    // ****************************************
    // Reference, pins and modulator tick
    // ****************************************
    logic [1:0]             clk_src;
    logic [1:0]             clk_div;
    logic [`PRESCALE_W-1:0] pre_cnt_reg;
    logic [`PRESCALE_W-1:0] pre_top;
    logic                   src_tick;
    logic                   tick_reg;
    logic [3:0]             osr_log2;
    logic [10:0]            osr_last;
    logic [4:0]             norm_shift;

    assign clk_src  = global_reg[`CLK_SRC_LSB +: 2];
    assign clk_div  = global_reg[`CLK_DIV_LSB +: 2];
    assign src_tick = (clk_src == 2'h0) ? 1'b1 : EXT_TICK;
    assign pre_top  = `PRESCALE_W'((4'h1 << clk_div) - 4'h1);

    // Ratio codes: normal 256, 128, 64, 32; extended 512, 1024, then 256 for the spare codes.
    always_comb
    begin
        case ({global_reg[`XOSR_BIT], global_reg[`OSR_LSB +: 2]})
            3'h0:    osr_log2 = 4'h8;
            3'h1:    osr_log2 = 4'h7;
            3'h2:    osr_log2 = 4'h6;
            3'h3:    osr_log2 = 4'h5;
            3'h4:    osr_log2 = 4'h9;
            3'h5:    osr_log2 = 4'ha;
            default: osr_log2 = 4'h8;
        endcase
    end
    assign osr_last   = 11'((12'h001 << osr_log2) - 12'h001);
    assign norm_shift = 5'(6'h1e - 6'(3 * osr_log2));

    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            pre_cnt_reg <= '0;
            tick_reg    <= 1'b0;
        end
        else
        begin
            tick_reg <= 1'b0;
            if (src_tick)
            begin
                if (pre_cnt_reg >= pre_top)
                begin
                    pre_cnt_reg <= '0;
                    tick_reg    <= 1'b1;
                end
                else
                    pre_cnt_reg <= pre_cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            REF_ON         <= 1'b0;
            REF_BUF_ON     <= 1'b0;
            EXT_REF_SEL    <= 1'b1;
            DIG_IN_DISABLE <= 8'h00;
        end
        else
        begin
            // The reference follows software only; channel power-down leaves it alone.
            REF_ON         <= global_reg[`REF_EN_BIT];
            REF_BUF_ON     <= global_reg[`REF_BUF_BIT];
            EXT_REF_SEL    <= ~global_reg[`REF_EN_BIT] & ~global_reg[`REF_BUF_BIT];
            DIG_IN_DISABLE <= pin_en_reg;
        end
    end

    assign PRDATA     = prdata_reg;
    assign PREADY     = pready_reg;
    assign PSLVERR    = pslverr_reg;
    assign MOD_STROBE = tick_reg;

    // ****************************************
    // Channels
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < `NUM_CH; g = g + 1)
        begin : chan
            sd_chan_pkg::chan_state_type state_reg;
            sd_chan_pkg::acc_type        int1_reg, int2_reg, int3_reg;
            sd_chan_pkg::acc_type        dly1_reg, dly2_reg, dly3_reg;
            sd_chan_pkg::acc_type        diff1, diff2, diff3, scaled;
            logic [10:0]                 dec_cnt_reg;
            logic                        start_reg;
            logic                        flag_reg;
            logic [2:0]                  pair_sh_reg, gain_sh_reg;
            logic [2:0]                  pair_reg, gain_reg;
            logic [1:0]                  delay_reg, buf_reg;
            logic [2:0]                  res_cnt_reg;
            logic [`RES_W-1:0]           result_reg;
            logic                        req_reg;
            logic                        sel;
            logic                        dec_step;
            logic                        changed;

            assign sel      = ch_hit && (ch_idx == 2'(g));
            assign dec_step = (state_reg == sd_chan_pkg::CH_RUN) && tick_reg
                              && (dec_cnt_reg >= osr_last);
            assign changed  = (pair_sh_reg != pair_reg) || (gain_sh_reg != gain_reg);

            // Differentiators close the comb; the difference wraps, which sinc3 tolerates.
            always_comb
            begin
                diff1  = int3_reg - dly1_reg;
                diff2  = diff1 - dly2_reg;
                diff3  = diff2 - dly3_reg;
                scaled = diff3 << norm_shift;
            end

            always_ff @(posedge SYS_CLK or negedge NRST)
            begin
                if (!NRST)
                begin
                    state_reg   <= sd_chan_pkg::CH_IDLE;
                    dec_cnt_reg <= 11'h000;
                    int1_reg    <= '0;
                    int2_reg    <= '0;
                    int3_reg    <= '0;
                    dly1_reg    <= '0;
                    dly2_reg    <= '0;
                    dly3_reg    <= '0;
                    result_reg  <= '0;
                end
                else
                begin
                    case (state_reg)
                        sd_chan_pkg::CH_IDLE:
                        begin
                            // Restarting from clean state makes every conversion repeatable.
                            dec_cnt_reg <= 11'h000;
                            int1_reg    <= '0;
                            int2_reg    <= '0;
                            int3_reg    <= '0;
                            dly1_reg    <= '0;
                            dly2_reg    <= '0;
                            dly3_reg    <= '0;
                            if (start_reg)
                                state_reg <= sd_chan_pkg::CH_RUN;
                        end
                        sd_chan_pkg::CH_RUN:
                        begin
                            if (!start_reg)
                                state_reg <= sd_chan_pkg::CH_IDLE;
                            else if (tick_reg)
                            begin
                                int1_reg <= int1_reg + {31'h0, MOD_BIT[g]};
                                int2_reg <= int2_reg + int1_reg;
                                int3_reg <= int3_reg + int2_reg;
                                dec_cnt_reg <= (dec_cnt_reg >= osr_last) ? 11'h000
                                               : dec_cnt_reg + 11'h001;
                                if (dec_step)
                                begin
                                    dly1_reg   <= int3_reg;
                                    dly2_reg   <= diff1;
                                    dly3_reg   <= diff2;
                                    result_reg <= scaled[30] ? 16'hffff : scaled[29:14];
                                end
                            end
                        end
                        default:
                            state_reg <= sd_chan_pkg::CH_IDLE;
                    endcase
                end
            end

            // Software settings; each channel owns its own copy.
            always_ff @(posedge SYS_CLK or negedge NRST)
            begin
                if (!NRST)
                begin
                    start_reg   <= 1'b0;
                    pair_sh_reg <= 3'h0;
                    gain_sh_reg <= 3'h0;
                    delay_reg   <= 2'h0;
                    buf_reg     <= 2'h0;
                end
                else if (wr_done && sel)
                begin
                    if (sub == `CH_CTRL_IDX)
                        start_reg <= PWDATA[`START_BIT];
                    if (sub == `CH_INPUT_IDX)
                    begin
                        pair_sh_reg <= PWDATA[`PAIR_LSB +: 3];
                        if (PWDATA[`GAIN_LSB +: 3] < `GAIN_LIMIT)
                            gain_sh_reg <= PWDATA[`GAIN_LSB +: 3];
                        delay_reg <= PWDATA[`DELAY_LSB +: 2];
                        buf_reg   <= PWDATA[`BUF_LSB +: 2];
                    end
                end
            end

            // Idle channels take new settings at once; running ones wait for the next decimation step.
            always_ff @(posedge SYS_CLK or negedge NRST)
            begin
                if (!NRST)
                begin
                    pair_reg <= 3'h0;
                    gain_reg <= 3'h0;
                end
                else if (state_reg == sd_chan_pkg::CH_IDLE || dec_step)
                begin
                    pair_reg <= pair_sh_reg;
                    gain_reg <= gain_sh_reg;
                end
            end

            // Results are counted from a start or an applied change; with a change on the
            // boundary the third result settles, otherwise the fourth, so delay 00 waits for 4.
            always_ff @(posedge SYS_CLK or negedge NRST)
            begin
                if (!NRST)
                    res_cnt_reg <= 3'h0;
                else if (state_reg == sd_chan_pkg::CH_IDLE)
                    res_cnt_reg <= 3'h0;
                else if (dec_step && changed)
                    res_cnt_reg <= 3'h0;
                else if (dec_step && res_cnt_reg < `IRQ_RESULT_MAX)
                    res_cnt_reg <= res_cnt_reg + 3'h1;
            end

            // A new result wins over a clear arriving in the same cycle.
            always_ff @(posedge SYS_CLK or negedge NRST)
            begin
                if (!NRST)
                    flag_reg <= 1'b0;
                else if (dec_step)
                    flag_reg <= 1'b1;
                else if (rd_done && sel && sub == `CH_RESULT_IDX)
                    flag_reg <= 1'b0;
                else if (wr_done && sel && sub == `CH_CTRL_IDX && !PWDATA[`FLAG_BIT])
                    flag_reg <= 1'b0;
            end

            always_ff @(posedge SYS_CLK or negedge NRST)
            begin
                if (!NRST)
                    req_reg <= 1'b0;
                else
                    req_reg <= flag_reg && (state_reg == sd_chan_pkg::CH_RUN)
                               && (res_cnt_reg >= (`IRQ_RESULT_MAX - {1'b0, delay_reg}));
            end

            assign ch_rd_bus[32*g +: 32] =
                (sub == `CH_CTRL_IDX)  ? {30'h0, flag_reg, start_reg} :
                (sub == `CH_INPUT_IDX) ? {22'h0, buf_reg, delay_reg, gain_sh_reg, pair_sh_reg} :
                                         {16'h0, result_reg};
            assign CH_POWER[g]         = (state_reg == sd_chan_pkg::CH_RUN);
            assign INPUT_SEL[3*g +: 3] = pair_reg;
            assign GAIN_SEL[3*g +: 3]  = gain_reg;
            assign BUF_SPEED[2*g +: 2] = buf_reg;
            assign CONV_REQ[g]         = req_reg;
        end
    endgenerate

endmodule

// *** rtl/sd_chan_defs.svh ***
// Offsets, field positions, reset values and counts for the sigma-delta channel control block.
// Assumes inclusion by its bare name from the design file and the package.
`ifndef SD_CHAN_DEFS_SVH
`define SD_CHAN_DEFS_SVH

// ****************************************
// Sizes
// ****************************************
`define NUM_CH          3
`define ADDR_W          8
`define ACC_W           32
`define RES_W           16

// ****************************************
// Register offsets (global byte addresses, channel block index and word indices)
// ****************************************
`define GLOBAL_CTRL_OFS 8'h00
`define PIN_ENABLE_OFS  8'h04
`define CH_BASE_OFS     4'h1
`define CH_CTRL_IDX     2'h0
`define CH_INPUT_IDX    2'h1
`define CH_RESULT_IDX   2'h2

// ****************************************
// Global control fields
// ****************************************
`define REF_EN_BIT      0
`define REF_BUF_BIT     1
`define CLK_SRC_LSB     2
`define CLK_DIV_LSB     4
`define OSR_LSB         6
`define XOSR_BIT        8
`define GLOBAL_RST      9'h000

// ****************************************
// Channel control and input control fields
// ****************************************
`define START_BIT       0
`define FLAG_BIT        1
`define PAIR_LSB        0
`define GAIN_LSB        3
`define DELAY_LSB       6
`define BUF_LSB         8
`define GAIN_LIMIT      3'h6
`define IRQ_RESULT_MAX  3'h4
`define PRESCALE_W      3

`endif

// *** rtl/sd_chan_pkg.sv ***
// Types shared by the sigma-delta channel control block.
// Assumes the constants header is on the include path.
`include "sd_chan_defs.svh"

package sd_chan_pkg;

    typedef enum logic {CH_IDLE, CH_RUN} chan_state_type;

    typedef logic [`ACC_W-1:0] acc_type;

endpackage
